// ==== verilog/rsc_reset_startup_control.sv ====
// Purpose: Reset merge, start-up timers, watchdog and config word
// Assumes: all inputs synchronous to clk; rcOscTick is the watchdog RC tick
// Notes:   reset is the power-on event of the device
// Operation
// - Watchdog is disabled only by a configuration bit, never at run time.
// - Watchdog counts ticks of its own RC oscillator, not the system clock.
// - Power-up delay of 72 ms runs after power-on only.
// - In crystal modes core stays in reset until oscillator edges are counted.
// - Sleep ends on external reset, watchdog timeout or enabled interrupt.
// - Configuration bits read zero when programmed, one when erased.
// - Configuration word lives at 2007h and erases to 3FFFh.
// - Configuration word reachable only in programming mode, not from code.
// - Two select bits decode into four oscillator modes.
// - Crystal modes also accept an external clock on the oscillator input.
// - Six reset causes are told apart and reported.
// - Registers outside reset keep value across all but power-on.
// - Most registers reset on power-on, pin, watchdog and supply-drop resets.
// - Watchdog wake from sleep resumes execution without any reset.
// - Expired and sleep flags follow the reset cause, except a pin reset in run, which leaves them unchanged.
// - Supply drop resets the device when its enable bit is set.
`timescale 1ns/1ps
module rsc_reset_startup_control #(
  parameter int PWRUP_CYCLES = rsc_pkg::PWRUP_CYCLES,
  parameter int SETTLE_EDGES = rsc_pkg::SETTLE_EDGES,
  parameter int WDT_TICKS    = rsc_pkg::WDT_TICKS
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irqOut,
  input  wire logic        extResetPinN,
  input  wire logic        supplyLow,
  input  wire logic        oscInPin,
  input  wire logic        rcOscTick,
  input  wire logic        intWake,
  input  wire logic        progMode,
  input  wire logic        progWrite,
  input  wire logic [13:0] progAddr,
  input  wire logic [13:0] progData,
  output logic      [13:0] progReadData,
  output logic             coreResetOut,
  output logic             coreStallOut,
  output logic             regResetPulse,
  output logic             wakePulse,
  output logic      [1:0]  oscModeOut,
  output logic             wdtExpiredFlag,
  output logic             sleepEnteredFlag
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  rsc_pkg::rsc_state_t state_ff;
  rsc_pkg::rsc_state_t nxt_state;
  rsc_pkg::rsc_cause_t cause_ff;
  rsc_pkg::rsc_osc_t   oscMode;
  logic [13:0]              cfg_ff;
  logic [31:0]              timer_ff;
  logic [31:0]              wdtCnt_ff;
  logic                     oscPrev_ff;
  logic                     resetting_ff;
  logic                     regReset_ff;
  logic                     wake_ff;
  logic                     expired_ff;
  logic                     slept_ff;
  logic [rsc_pkg::IRQ_W-1:0] irqStat_ff;
  logic [rsc_pkg::IRQ_W-1:0] irqMask_ff;
  logic [rsc_pkg::IRQ_W-1:0] irqEv;
  logic [31:0]              rdData_ff;
  logic [13:0]              progRd_ff;
  logic                     extRst;
  logic                     dropRst;
  logic                     wdtEn;
  logic                     wdtFire;
  logic                     crystal;
  logic                     oscEdge;
  logic                     sleeping;
  logic                     resetEvt;
  logic                     wakeEvt;
  logic                     srcActive;
  logic                     access;
  logic                     wrCtrl;
  logic                     kick;
  logic                     sleepReq;
  logic                     mapped;

  ////////////////////////////////////////////////////////////////////////
  // Source decode
  // Active high enable bits
  assign oscMode  = rsc_pkg::rsc_osc_t'(cfg_ff[rsc_pkg::CFG_OSC_LO +: 2]);
  assign wdtEn    = cfg_ff[rsc_pkg::CFG_WDT_EN];
  assign dropRst  = supplyLow & cfg_ff[rsc_pkg::CFG_DROP_EN];
  assign extRst   = ~extResetPinN;
  assign crystal  = (oscMode != rsc_pkg::OSC_RESISTOR_CAPACITOR);
  // Crystal or driven clock, edges counted alike
  assign oscEdge  = oscInPin & ~oscPrev_ff;
  assign sleeping = (state_ff == rsc_pkg::ST_SLEEP);
  assign srcActive = extRst | dropRst;

  // Watchdog only runs while the core runs or sleeps
  // Counted on RC ticks
  assign wdtFire = wdtEn & rcOscTick & (wdtCnt_ff == 32'(WDT_TICKS - 1)) &
                   ((state_ff == rsc_pkg::ST_RUN) | sleeping);

  assign resetEvt = srcActive | (wdtFire & ~sleeping);
  assign wakeEvt  = sleeping & (wdtFire | intWake) & ~srcActive;

  ////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, read data captured in setup
  assign access   = psel & penable;
  assign mapped   = (paddr == rsc_pkg::ADDR_CTRL) | (paddr == rsc_pkg::ADDR_STATUS) |
                    (paddr == rsc_pkg::ADDR_IRQ_STAT) | (paddr == rsc_pkg::ADDR_IRQ_MASK);
  assign wrCtrl   = access & pwrite & (paddr == rsc_pkg::ADDR_CTRL);
  // Software may only restart the watchdog
  assign kick     = wrCtrl & pwdata[rsc_pkg::CTRL_KICK];
  assign sleepReq = wrCtrl & pwdata[rsc_pkg::CTRL_SLEEP];
  assign pready   = access;
  assign pslverr  = access & ~mapped;
  assign prdata   = rdData_ff;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rsc_pkg::ST_PWRUP: begin
        if (timer_ff == 32'(PWRUP_CYCLES - 1)) begin
          nxt_state = rsc_pkg::ST_SETTLE;
        end
      end
      rsc_pkg::ST_SETTLE: begin
        if (srcActive) begin
          nxt_state = rsc_pkg::ST_SETTLE;
        end else if (!crystal) begin
          nxt_state = rsc_pkg::ST_RUN;
        end else if (oscEdge && timer_ff == 32'(SETTLE_EDGES - 1)) begin
          nxt_state = rsc_pkg::ST_RUN;
        end
      end
      rsc_pkg::ST_RUN: begin
        if (resetEvt) begin
          nxt_state = rsc_pkg::ST_SETTLE;
        end else if (sleepReq) begin
          nxt_state = rsc_pkg::ST_SLEEP;
        end
      end
      rsc_pkg::ST_SLEEP: begin
        if (resetEvt || wakeEvt) begin
          nxt_state = rsc_pkg::ST_SETTLE;
        end
      end
      default: nxt_state = rsc_pkg::ST_PWRUP;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= rsc_pkg::ST_PWRUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Shared start-up timer; the two delays never overlap
  // Lengths set by parameters
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_ff <= 32'h0;
    end else if (nxt_state != state_ff || (state_ff == rsc_pkg::ST_SETTLE && srcActive)) begin
      timer_ff <= 32'h0;
    end else if (state_ff == rsc_pkg::ST_PWRUP) begin
      timer_ff <= timer_ff + 32'h1;
    end else if (state_ff == rsc_pkg::ST_SETTLE && oscEdge) begin
      timer_ff <= timer_ff + 32'h1;
    end
  end

  // Oscillator pin history for edge counting
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oscPrev_ff <= 1'b0;
    end else begin
      oscPrev_ff <= oscInPin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog counter, cleared by kick, sleep entry and every reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdtCnt_ff <= 32'h0;
    end else if (kick || sleepReq || resetEvt || wdtFire || !wdtEn) begin
      wdtCnt_ff <= 32'h0;
    end else if (rcOscTick && (state_ff == rsc_pkg::ST_RUN || sleeping)) begin
      wdtCnt_ff <= wdtCnt_ff + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core reset and pulses
  // Released only on entry to run
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      resetting_ff <= 1'b1;
    end else if (resetEvt) begin
      resetting_ff <= 1'b1;
    end else if (nxt_state == rsc_pkg::ST_RUN) begin
      resetting_ff <= 1'b0;
    end
  end

  // Not raised at power-on; that class stays undefined there
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regReset_ff <= 1'b0;
      wake_ff     <= 1'b0;
    end else begin
      regReset_ff <= resetEvt;
      wake_ff     <= wakeEvt;
    end
  end

  assign coreResetOut  = resetting_ff;
  assign coreStallOut  = (state_ff != rsc_pkg::ST_RUN);
  assign regResetPulse = regReset_ff;
  assign wakePulse     = wake_ff;
  assign oscModeOut    = oscMode;

  ////////////////////////////////////////////////////////////////////////
  // Cause and flags
  // Cause priority: drop, pin, watchdog
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cause_ff   <= rsc_pkg::CAUSE_POWER_ON;
      expired_ff <= 1'b0;
      slept_ff   <= 1'b0;
    end else if (dropRst) begin
      cause_ff   <= rsc_pkg::CAUSE_DROP;
      expired_ff <= 1'b0;
      slept_ff   <= 1'b0;
    end else if (extRst && sleeping) begin
      cause_ff   <= rsc_pkg::CAUSE_PIN_SLEEP;
      expired_ff <= 1'b0;
      slept_ff   <= 1'b1;
    end else if (extRst && !resetting_ff) begin // A held pin keeps the cause of the edge that began the reset
      cause_ff   <= rsc_pkg::CAUSE_PIN_RUN;
    end else if (wdtFire && sleeping) begin
      cause_ff   <= rsc_pkg::CAUSE_WDT_WAKE;
      expired_ff <= 1'b1;
      slept_ff   <= 1'b1;
    end else if (wdtFire) begin
      cause_ff   <= rsc_pkg::CAUSE_WDT_RUN;
      expired_ff <= 1'b1;
      slept_ff   <= 1'b0;
    end else if (sleepReq && state_ff == rsc_pkg::ST_RUN) begin
      expired_ff <= 1'b0;
      slept_ff   <= 1'b1;
    end else if (kick) begin
      expired_ff <= 1'b0;
      slept_ff   <= 1'b0;
    end
  end

  assign wdtExpiredFlag   = expired_ff;
  assign sleepEnteredFlag = slept_ff;

  ////////////////////////////////////////////////////////////////////////
  // Configuration word, seen by the programming port only
  // Erased value and address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_ff <= rsc_pkg::CFG_ERASED;
    end else if (progMode && progWrite && progAddr == rsc_pkg::CFG_ADDR) begin
      cfg_ff <= progData;
    end
  end

  // Read back is blanked outside programming mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      progRd_ff <= 14'h0;
    end else if (progMode && progAddr == rsc_pkg::CFG_ADDR) begin
      progRd_ff <= cfg_ff;
    end else begin
      progRd_ff <= 14'h0;
    end
  end

  assign progReadData = progRd_ff;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status; a new event beats a same-cycle clear
  assign irqEv = {wakeEvt, extRst, dropRst, wdtFire};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqStat_ff <= rsc_pkg::IRQ_RESET_VAL;
    end else if (access && pwrite && paddr == rsc_pkg::ADDR_IRQ_STAT) begin
      irqStat_ff <= (irqStat_ff & ~pwdata[rsc_pkg::IRQ_W-1:0]) | irqEv;
    end else begin
      irqStat_ff <= irqStat_ff | irqEv;
    end
  end

  // Mask register, one enables the bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqMask_ff <= rsc_pkg::IRQ_RESET_VAL;
    end else if (access && pwrite && paddr == rsc_pkg::ADDR_IRQ_MASK) begin
      irqMask_ff <= pwdata[rsc_pkg::IRQ_W-1:0];
    end
  end

  assign irqOut = |(irqStat_ff & irqMask_ff);

  ////////////////////////////////////////////////////////////////////////
  // Read data, sampled in setup so the access phase is one cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData_ff <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        rsc_pkg::ADDR_STATUS:   rdData_ff <= {24'h0, sleeping, oscMode, cause_ff, slept_ff, expired_ff};
        rsc_pkg::ADDR_IRQ_STAT: rdData_ff <= {28'h0, irqStat_ff};
        rsc_pkg::ADDR_IRQ_MASK: rdData_ff <= {28'h0, irqMask_ff};
        default:                rdData_ff <= 32'h0;
      endcase
    end
  end

endmodule : rsc_reset_startup_control

// ==== verilog/rsc_pkg.sv ====
// Purpose: Shared constants for the reset and start-up controller
// Assumes: 40 MHz system clock, APB register access
// Notes:   Configuration bits read 0 when programmed, 1 when erased
package rsc_pkg;
  // Clock and start-up timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int PWRUP_MS      = 72;
  localparam int PWRUP_CYCLES  = PWRUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SETTLE_EDGES  = 1024;
  localparam int WDT_TICKS     = 256;

  // Configuration word
  localparam logic [13:0] CFG_ADDR     = 14'h2007;
  localparam logic [13:0] CFG_ERASED   = 14'h3fff;
  localparam int          CFG_OSC_LO   = 0;
  localparam int          CFG_WDT_EN   = 2;
  localparam int          CFG_DROP_EN  = 6;

  // APB map, byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam int         CTRL_KICK     = 0;
  localparam int         CTRL_SLEEP    = 1;
  localparam int         IRQ_W         = 4;
  localparam logic [3:0] IRQ_RESET_VAL = 4'h0;

  // Oscillator modes, decoded from two select bits
  typedef enum logic [1:0] {
    OSC_LOW_POWER_CRYSTAL  = 2'h0,
    OSC_CRYSTAL_RESONATOR  = 2'h1,
    OSC_HIGH_SPEED_CRYSTAL = 2'h2,
    OSC_RESISTOR_CAPACITOR = 2'h3
  } rsc_osc_t;

  // Reset causes
  typedef enum logic [2:0] {
    CAUSE_POWER_ON  = 3'h0,
    CAUSE_PIN_RUN   = 3'h1,
    CAUSE_PIN_SLEEP = 3'h2,
    CAUSE_WDT_RUN   = 3'h3,
    CAUSE_WDT_WAKE  = 3'h4,
    CAUSE_DROP      = 3'h5
  } rsc_cause_t;

  // Sequencer states, Gray along power-up, settle, run, sleep
  typedef enum logic [1:0] {
    ST_PWRUP  = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b11,
    ST_SLEEP  = 2'b10
  } rsc_state_t;
endpackage : rsc_pkg

// ==== test/rsc_reset_startup_control_assertions.sv ====
// Purpose: Port checks for the reset and start-up controller
// Assumes: one clock domain, reset is the power-on event
// Notes:   Config-dependent behaviour is judged by the bench instead
`timescale 1ns/1ps
module rsc_checker #(
  parameter int PWRUP_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        irqOut,
  input wire logic        extResetPinN,
  input wire logic        progMode,
  input wire logic        progWrite,
  input wire logic [13:0] progAddr,
  input wire logic [13:0] progReadData,
  input wire logic        coreResetOut,
  input wire logic        coreStallOut,
  input wire logic        regResetPulse,
  input wire logic        wakePulse,
  input wire logic [1:0]  oscModeOut
);
  int pwrCnt_ff;
  // Saturating count since power-on release, so it never wraps
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwrCnt_ff <= 0;
    end else if (pwrCnt_ff < PWRUP_CYCLES) begin
      pwrCnt_ff <= pwrCnt_ff + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // Reset merge and start-up hold
  AST_PWRUP_HOLD: assert property (pwrCnt_ff < PWRUP_CYCLES |-> coreResetOut)
    else $error("core left reset inside power-up delay");
  AST_PIN_RESET: assert property (!extResetPinN && !coreResetOut |=> regResetPulse)
    else $error("pin reset gave no register reset");
  AST_PIN_HOLD: assert property (!extResetPinN |=> coreResetOut)
    else $error("core free while pin held low");
  AST_RESET_STALL: assert property (coreResetOut |-> coreStallOut)
    else $error("core running while held in reset");
  // Wake from sleep
  AST_WAKE_NO_RESET: assert property (wakePulse |-> !regResetPulse && !coreResetOut)
    else $error("wake treated as reset");
  AST_WAKE_ONCE: assert property (wakePulse |=> !wakePulse)
    else $error("wake pulse longer than one cycle");
  // Config word access and decode
  AST_CFG_HIDDEN: assert property (!progMode |=> progReadData == 14'h0)
    else $error("config word visible outside programming");
  AST_CFG_ADDR: assert property (progMode && progAddr != rsc_pkg::CFG_ADDR |=> progReadData == 14'h0)
    else $error("config word seen at wrong address");
  AST_OSC_HOLD: assert property (!(progMode && progWrite) |=> $stable(oscModeOut))
    else $error("oscillator mode changed without write");
  COV_WAKE: cover property (wakePulse);
  COV_RESET: cover property (regResetPulse);
  COV_IRQ: cover property (irqOut ##1 !irqOut);
endmodule : rsc_checker
bind rsc_reset_startup_control rsc_checker #(.PWRUP_CYCLES(PWRUP_CYCLES)) rsc_checker_i (
  .clk, .reset, .irqOut, .extResetPinN, .progMode, .progWrite, .progAddr, .progReadData,
  .coreResetOut, .coreStallOut, .regResetPulse, .wakePulse, .oscModeOut);

// ==== test/rsc_far_side_model.sv ====
// Purpose: Far side of reset pin, supply monitor and oscillator input
// Assumes: requests come from the bench, synchronous to clk
// Notes:   Oscillator stands low when stopped, so no stray edges count
`timescale 1ns/1ps
module rsc_far_side_model (
  input  wire logic clk,
  input  wire logic pinReq,
  input  wire logic dropReq,
  input  wire logic oscRun,
  output logic      extResetPinN,
  output logic      supplyLow,
  output logic      oscInPin
);
  logic oscPhase_ff = 1'b0;
  assign extResetPinN = !pinReq;
  assign supplyLow = dropReq;
  always_ff @(posedge clk) begin
    oscPhase_ff <= oscRun ? !oscPhase_ff : 1'b0;
  end
  assign oscInPin = oscPhase_ff;
endmodule : rsc_far_side_model

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the reset and start-up controller
// Assumes: short timer parameters, far-side model on pins and oscillator
// Notes:   Mask values and tick gaps come from a fixed xorshift seed
`timescale 1ns/1ps
module tb;
  localparam int         PWRUP = 20;
  localparam int         TICKS = 4;
  localparam logic [7:0] CT    = rsc_pkg::ADDR_CTRL;
  localparam logic [7:0] IS    = rsc_pkg::ADDR_IRQ_STAT;
  localparam logic [7:0] IM    = rsc_pkg::ADDR_IRQ_MASK;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, irqOut;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rs;
  logic        extResetPinN, supplyLow, oscInPin, rcOscTick, intWake;
  logic        progMode, progWrite, coreResetOut, coreStallOut, pinReq, dropReq, oscRun;
  logic        regResetPulse, wakePulse, wdtExpiredFlag, sleepEnteredFlag;
  logic [13:0] progAddr, progData, progReadData;
  logic [1:0]  oscModeOut;
  int          errTotal, numChecks, cyc, wakeCnt;
  rsc_reset_startup_control #(.PWRUP_CYCLES(PWRUP), .SETTLE_EDGES(4), .WDT_TICKS(TICKS))
    rsc_reset_startup_control_i (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irqOut, .extResetPinN, .supplyLow, .oscInPin, .rcOscTick,
    .intWake, .progMode, .progWrite, .progAddr, .progData, .progReadData, .coreResetOut,
    .coreStallOut, .regResetPulse, .wakePulse, .oscModeOut, .wdtExpiredFlag, .sleepEnteredFlag);
  rsc_far_side_model rsc_far_side_model_i (.clk, .pinReq, .dropReq, .oscRun, .extResetPinN,
    .supplyLow, .oscInPin);
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // Wake counting and hang guard
  always @(posedge clk) begin
    cyc++;
    if (wakePulse === 1'b1) wakeCnt++;
    if (cyc == 20000) begin
      errTotal++;
      stopTest();
    end
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  // Expected status word from flags, cause, mode and sleep state
  function automatic logic [31:0] st(logic e, logic s, logic [2:0] c, logic [1:0] o, logic sl);
    return {24'h0, sl, o, c, s, e};
  endfunction : st
  task automatic chk(logic [31:0] g, logic [31:0] x);
    numChecks++;
    if (g !== x) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      errTotal++;
    end
  endtask : chk
  // One bus transfer; the trailing idle edge keeps psel from being driven twice at once
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(logic [7:0] a, logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rd
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr
  task automatic rdSt(logic e, logic s, logic [2:0] c, logic [1:0] o, logic sl);
    rd(rsc_pkg::ADDR_STATUS, st(e, s, c, o, sl));
    chk({30'h0, sleepEnteredFlag, wdtExpiredFlag}, {30'h0, s, e});
  endtask : rdSt
  // Wait for the core to run again, bounded
  task automatic waitRel();
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while ((coreResetOut !== 1'b0 || coreStallOut !== 1'b0) && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n == 400}, 32'h0);
  endtask : waitRel
  task automatic tick(int k);
    repeat (k) begin
      rcOscTick <= 1'b1;
      @(posedge clk);
      rcOscTick <= 1'b0;
      repeat (1 + rnd() % 3) @(posedge clk);
    end
  endtask : tick
  task automatic hit(logic drop);
    pinReq  <= !drop;
    dropReq <= drop;
    repeat (2) @(posedge clk);
    pinReq  <= 1'b0;
    dropReq <= 1'b0;
  endtask : hit
  task automatic stopTest();
    $display("checks=%0d errors=%0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stopTest
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [31:0] m;
    logic        e;
    rs = 32'hf5d2b932;
    clk = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, rcOscTick, intWake, progMode, progWrite, pinReq, dropReq, oscRun} = '0;
    {paddr, pwdata, progAddr, progData} = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    waitRel();
    rdSt(0, 0, 3'h0, 2'h3, 0);
    rd(IM, 32'h0);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    repeat (3) begin
      m = rnd() & 32'hf;
      wr(IM, m);
      rd(IM, m);
    end
    // Watchdog in run: one tick short, then the timeout
    wr(CT, 32'h1);
    tick(TICKS - 1);
    chk({31'h0, coreResetOut}, 32'h0);
    tick(1);
    waitRel();
    rdSt(1, 0, 3'h3, 2'h3, 0);
    wr(CT, 32'h1);
    rdSt(0, 0, 3'h3, 2'h3, 0);
    // Watchdog wake from sleep raises the masked-in interrupt only
    wr(IS, 32'hf);
    wr(IM, 32'h1);
    wr(CT, 32'h2);
    rdSt(0, 1, 3'h3, 2'h3, 1);
    tick(TICKS);
    waitRel();
    rdSt(1, 1, 3'h4, 2'h3, 0);
    chk(wakeCnt, 1);
    chk({31'h0, irqOut}, 32'h1);
    wr(IS, 32'h1);
    @(posedge clk);
    chk({31'h0, irqOut}, 32'h0);
    wr(CT, 32'h2);
    intWake <= 1'b1;
    waitRel();
    intWake <= 1'b0;
    rdSt(0, 1, 3'h4, 2'h3, 0);
    chk(wakeCnt, 2);
    // Pin reset in sleep, pin reset in run, supply drop
    wr(CT, 32'h2);
    hit(1'b0);
    waitRel();
    rdSt(0, 1, 3'h2, 2'h3, 0);
    hit(1'b0);
    waitRel();
    rdSt(0, 1, 3'h1, 2'h3, 0);
    hit(1'b1);
    waitRel();
    rdSt(0, 0, 3'h5, 2'h3, 0);
    // Config word: crystal/resonator mode, watchdog off
    progAddr <= rsc_pkg::CFG_ADDR;
    progMode <= 1'b1;
    repeat (2) @(posedge clk);
    chk({18'h0, progReadData}, {18'h0, rsc_pkg::CFG_ERASED});
    progData  <= 14'h3ff9;
    progWrite <= 1'b1;
    @(posedge clk);
    progWrite <= 1'b0;
    repeat (2) @(posedge clk);
    chk({18'h0, progReadData}, 32'h3ff9);
    chk({30'h0, oscModeOut}, 32'h1);
    progAddr <= 14'h0;
    repeat (2) @(posedge clk);
    chk({18'h0, progReadData}, 32'h0);
    progMode <= 1'b0;
    hit(1'b0);
    repeat (30) @(posedge clk);
    chk({31'h0, coreResetOut}, 32'h1);
    oscRun <= 1'b1;
    waitRel();
    oscRun <= 1'b0;
    rdSt(0, 0, 3'h1, 2'h1, 0);
    tick(2 * TICKS);
    chk({31'h0, coreResetOut}, 32'h0);
    // Remaining crystal modes from the two select bits
    progMode  <= 1'b1;
    progAddr  <= rsc_pkg::CFG_ADDR;
    progData  <= 14'h3ff8;
    progWrite <= 1'b1;
    @(posedge clk);
    progData  <= 14'h3ffa;
    @(posedge clk);
    chk({30'h0, oscModeOut}, 32'h0);
    progWrite <= 1'b0;
    @(posedge clk);
    chk({30'h0, oscModeOut}, 32'h2);
    progMode  <= 1'b0;
    @(posedge clk);
    stopTest();
  end
endmodule : tb
